//--- ahs_pkg.sv
// Purpose: shared constants and types for the axis homing and spindle output block
// Assumes: 200 MHz clock, one clock domain
// Notes: homing action codes are what the host places on the per-axis mode ports
package ahs_pkg;
	localparam int AHS_CLK_MHZ = 200;
	localparam int AHS_NUM_AXES = 8;
	localparam int AHS_NUM_IDX = 3;
	localparam int AHS_STEP_W = 16;
	localparam int AHS_POS_W = 32;
	localparam int AHS_PWM_W = 16;
	// Homing mode encodings
	localparam logic [1:0] AHS_MODE_STD = 2'h0;
	localparam logic [1:0] AHS_MODE_SLOW = 2'h1;
	localparam logic [1:0] AHS_MODE_IDX = 2'h2;
	localparam logic [1:0] AHS_MODE_RST = AHS_MODE_STD;
	localparam logic [AHS_STEP_W-1:0] AHS_BACKOFF_RST = 16'h0000;
	localparam logic [AHS_PWM_W-1:0] AHS_PWM_PERIOD_RST = 16'h2710;
	typedef enum logic [2:0] {
		AHS_IDLE,
		AHS_SEEK,
		AHS_ON_SW,
		AHS_ARMED,
		AHS_BACKOFF,
		AHS_DONE
	} ahs_state_t;
endpackage

//--- ahs_spindle_pwm.sv
// Purpose: spindle PWM generator, duty proportional to commanded speed
// Assumes: speed_max_in nonzero when enabled
// Notes: the division is done once per period and held
`timescale 1ns/10ps
module ahs_spindle_pwm import ahs_pkg::*; #(
	parameter int W = AHS_PWM_W
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic enable_in,
	input wire logic [W-1:0] period_in,
	input wire logic [W-1:0] speed_in,
	input wire logic [W-1:0] speed_max_in,
	output logic pwm_out
);
	if (W < 2 || W > 16) begin : g_bad_w
		$error("ahs_spindle_pwm: W out of range");
	end
	logic [W-1:0] cnt_r, cnt_nxt;
	logic [W-1:0] thr_r, thr_nxt;
	logic pwm_r, pwm_nxt;
	logic [2*W-1:0] prod;
	logic [W-1:0] spd;

	////////////////////////////////////////////////////////////////////////
	// Period counter, threshold update at period start, compare
	always_comb begin
		spd = (speed_in > speed_max_in) ? speed_max_in : speed_in;
		prod = spd * period_in;
		cnt_nxt = cnt_r;
		thr_nxt = thr_r;
		if (!enable_in) begin
			cnt_nxt = '0;
			thr_nxt = '0;
		end else if (cnt_r + 1'b1 >= period_in) begin
			cnt_nxt = '0;
			// Max speed gives threshold equal to period, so full duty [R12]
			thr_nxt = (speed_max_in == '0) ? '0 : W'(prod / speed_max_in);
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
		// Disabled channel drives nothing
		pwm_nxt = enable_in && (cnt_nxt < thr_nxt);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_r <= '0;
			thr_r <= '0;
			pwm_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			thr_r <= thr_nxt;
			pwm_r <= pwm_nxt;
		end
	end
	assign pwm_out = pwm_r;

	a_pwm_off_disabled: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!enable_in |=> !pwm_out) else $error("pwm active while disabled"); // [R14]
endmodule

//--- ahs_top.sv
// Purpose: per-axis homing sequencing, limit supervision and spindle PWM
// Assumes: switch and index pins are asynchronous; host drives config ports
// Notes: motion itself is commanded through the per-axis action outputs
// Notes on behaviour
// R1: Standard mode slows and reverses on home hit, then zeroes and stops on release.
// R2: Alternative mode only slows on home hit, then zeroes and stops on release.
// R3: Index mode slows on home hit and arms the axis index input at that moment; axes beyond the third have no channel and home as in alternative mode.
// R4: An armed index zeroes and stops the axis at the next index transition.
// R5: Index channels are fixed: axis 0 uses channel 1, axis 1 channel 2, axis 2 channel 3.
// R6: After reset every axis uses standard homing until reconfigured.
// R7: With back-off set, the axis steps away from the switch by that many pulses after homing.
// R8: A limit going active on an axis that is not homing raises emergency stop.
// R9: While any homing runs, limits of shared axes that are homing or homed are ignored.
// R10: The host wires a series switch as limit-minus of the first axis, others home only.
// R11: A shared series switch hit outside homing is reported against the first axis.
// R12: Spindle PWM duty follows commanded speed, with maximum speed giving full duty.
// R13: The host sets a 20000 Hz PWM rate when feeding a 0-10 V converter.
// R14: The host enables the spindle channel; a disabled channel gives no drive.
// R15: The armed index is dropped on position reset or homing abort.
`timescale 1ns/10ps
module ahs_top import ahs_pkg::*; #(
	parameter int N = AHS_NUM_AXES
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [N-1:0] home_start_in,
	input wire logic home_abort_in,
	input wire logic [2*N-1:0] home_mode_in,
	input wire logic mode_load_in,
	input wire logic [AHS_STEP_W-1:0] backoff_steps_in,
	input wire logic [N-1:0] shared_limit_in,
	input wire logic [N-1:0] home_sw_in,
	input wire logic [N-1:0] limit_sw_in,
	input wire logic [AHS_NUM_IDX-1:0] index_in,
	input wire logic [N-1:0] step_pulse_in,
	input wire logic pwm_enable_in,
	input wire logic [AHS_PWM_W-1:0] pwm_period_in,
	input wire logic [AHS_PWM_W-1:0] spindle_speed_in,
	input wire logic [AHS_PWM_W-1:0] spindle_max_in,
	output logic [N-1:0] slow_out,
	output logic [N-1:0] reverse_out,
	output logic [N-1:0] stop_out,
	output logic [N-1:0] pos_zero_out,
	output logic [N-1:0] homing_out,
	output logic [N-1:0] homed_out,
	output logic [N-1:0] index_armed_out,
	output logic estop_out,
	output logic [N-1:0] limit_src_out,
	output logic spindle_pwm_out
);
	if (N < AHS_NUM_IDX || N > 16) begin : g_bad_n
		$error("ahs_top: N out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Three-stage synchronisers for pins; second and third stages are compared
	localparam int NS = 2*N + AHS_NUM_IDX;
	logic [NS-1:0] s1_r, s2_r, s3_r, stable_r;
	logic [NS-1:0] s1_nxt, s2_nxt, s3_nxt, stable_nxt;
	always_comb begin
		s1_nxt = {index_in, limit_sw_in, home_sw_in};
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		stable_nxt = stable_r;
		for (int i = 0; i < NS; i++) begin
			if (s2_r[i] == s3_r[i]) stable_nxt[i] = s3_r[i];
		end
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			stable_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			stable_r <= stable_nxt;
		end
	end
	logic [N-1:0] home_s, lim_s;
	logic [AHS_NUM_IDX-1:0] idx_s;
	assign home_s = stable_r[N-1:0];
	assign lim_s = stable_r[2*N-1:N];
	assign idx_s = stable_r[NS-1:2*N];

	////////////////////////////////////////////////////////////////////////
	// Mode register; standard homing after reset
	logic [2*N-1:0] mode_r, mode_nxt;
	always_comb begin
		mode_nxt = mode_r;
		if (mode_load_in) mode_nxt = home_mode_in;
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_r <= {N{AHS_MODE_RST}}; // [R6]
		end else begin
			mode_r <= mode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Index edge detect on the stable level, previous stable kept
	logic [AHS_NUM_IDX-1:0] idx_prev_r, idx_prev_nxt, idx_edge;
	always_comb begin
		idx_prev_nxt = idx_s;
		idx_edge = idx_s ^ idx_prev_r;
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) idx_prev_r <= '0;
		else idx_prev_r <= idx_prev_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Per-axis homing machines
	ahs_state_t st_r [N];
	ahs_state_t st_nxt [N];
	logic [AHS_STEP_W-1:0] bo_r [N];
	logic [AHS_STEP_W-1:0] bo_nxt [N];
	logic [N-1:0] slow_r, rev_r, stop_r, zero_r, arm_r;
	logic [N-1:0] slow_nxt, rev_nxt, stop_nxt, zero_nxt, arm_nxt;

	// Fixed index channel for an axis; none beyond the third axis
	function automatic logic idx_of(input int a, input logic [AHS_NUM_IDX-1:0] e);
		idx_of = (a < AHS_NUM_IDX) ? e[a] : 1'b0; // [R5]
	endfunction

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_axis
			logic [1:0] md;
			assign md = mode_r[2*g+1:2*g];
			always_comb begin
				st_nxt[g] = st_r[g];
				bo_nxt[g] = bo_r[g];
				slow_nxt[g] = slow_r[g];
				rev_nxt[g] = rev_r[g];
				stop_nxt[g] = 1'b0;
				zero_nxt[g] = 1'b0;
				arm_nxt[g] = arm_r[g];
				case (st_r[g])
					AHS_IDLE, AHS_DONE: begin
						if (home_start_in[g]) begin
							st_nxt[g] = AHS_SEEK;
							slow_nxt[g] = 1'b0;
							rev_nxt[g] = 1'b0;
						end
					end
					AHS_SEEK: begin
						if (home_s[g]) begin
							slow_nxt[g] = 1'b1; // [R1] [R2] [R3]
							if (md == AHS_MODE_IDX && g < AHS_NUM_IDX) begin
								arm_nxt[g] = 1'b1; // [R3]
								st_nxt[g] = AHS_ARMED;
							end else begin
								rev_nxt[g] = (md == AHS_MODE_STD); // [R1]
								st_nxt[g] = AHS_ON_SW;
							end
						end
					end
					AHS_ON_SW: begin
						if (!home_s[g]) begin
							zero_nxt[g] = 1'b1; // [R1] [R2]
							stop_nxt[g] = 1'b1;
							st_nxt[g] = (backoff_steps_in != '0) ? AHS_BACKOFF : AHS_DONE;
							bo_nxt[g] = backoff_steps_in;
						end
					end
					AHS_ARMED: begin
						if (idx_of(g, idx_edge)) begin
							zero_nxt[g] = 1'b1; // [R4]
							stop_nxt[g] = 1'b1;
							arm_nxt[g] = 1'b0; // [R15]
							st_nxt[g] = (backoff_steps_in != '0) ? AHS_BACKOFF : AHS_DONE;
							bo_nxt[g] = backoff_steps_in;
						end
					end
					AHS_BACKOFF: begin
						// Move away from the switch, counting step pulses [R7]
						slow_nxt[g] = 1'b1;
						rev_nxt[g] = 1'b1;
						if (step_pulse_in[g]) bo_nxt[g] = bo_r[g] - 1'b1;
						if (bo_r[g] == '0 || (step_pulse_in[g] && bo_r[g] == 16'h0001)) begin
							stop_nxt[g] = 1'b1;
							st_nxt[g] = AHS_DONE;
						end
					end
					default: st_nxt[g] = AHS_IDLE;
				endcase
				if (home_abort_in) begin
					st_nxt[g] = AHS_IDLE;
					arm_nxt[g] = 1'b0; // [R15]
					stop_nxt[g] = (st_r[g] != AHS_IDLE && st_r[g] != AHS_DONE);
				end
				if (st_nxt[g] == AHS_DONE || st_nxt[g] == AHS_IDLE) begin
					slow_nxt[g] = 1'b0;
					rev_nxt[g] = 1'b0;
				end
			end
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					st_r[g] <= AHS_IDLE;
					bo_r[g] <= AHS_BACKOFF_RST;
				end else begin
					st_r[g] <= st_nxt[g];
					bo_r[g] <= bo_nxt[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			slow_r <= '0;
			rev_r <= '0;
			stop_r <= '0;
			zero_r <= '0;
			arm_r <= '0;
		end else begin
			slow_r <= slow_nxt;
			rev_r <= rev_nxt;
			stop_r <= stop_nxt;
			zero_r <= zero_nxt;
			arm_r <= arm_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Homing status and limit supervision
	logic [N-1:0] homing_v, homed_r, homed_nxt, lim_prev_r, lim_prev_nxt;
	logic [N-1:0] homing_r, homing_nxt, src_r, src_nxt;
	logic estop_r, estop_nxt;
	logic [N-1:0] mask, rise;
	always_comb begin
		for (int i = 0; i < N; i++) begin
			homing_v[i] = (st_r[i] != AHS_IDLE) && (st_r[i] != AHS_DONE);
		end
		homed_nxt = homed_r;
		for (int i = 0; i < N; i++) begin
			// Completion wins over a refused start in the same cycle
			if (home_start_in[i] || home_abort_in) homed_nxt[i] = 1'b0;
			if (st_r[i] != AHS_DONE && st_nxt[i] == AHS_DONE) homed_nxt[i] = 1'b1;
		end
		homing_nxt = homing_v;
		lim_prev_nxt = lim_s;
		rise = lim_s & ~lim_prev_r;
		// Shared axes homing or homed while any homing runs are masked [R9]
		mask = homing_v | ({N{|homing_v}} & shared_limit_in & homed_r);
		estop_nxt = estop_r;
		src_nxt = src_r;
		for (int i = 0; i < N; i++) begin
			if (rise[i] && !mask[i]) begin
				estop_nxt = 1'b1; // [R8]
				// Source bit names the axis whose limit rose; the series switch sits on the first axis [R11]
				src_nxt[i] = 1'b1;
			end
		end
		if (home_start_in != '0 || home_abort_in) begin
			// New event wins over the clear
			estop_nxt = |(rise & ~mask);
			src_nxt = rise & ~mask;
		end
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			homed_r <= '0;
			homing_r <= '0;
			lim_prev_r <= '0;
			estop_r <= 1'b0;
			src_r <= '0;
		end else begin
			homed_r <= homed_nxt;
			homing_r <= homing_nxt;
			lim_prev_r <= lim_prev_nxt;
			estop_r <= estop_nxt;
			src_r <= src_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Spindle PWM
	ahs_spindle_pwm #(.W(AHS_PWM_W)) i_ahs_spindle_pwm (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.enable_in(pwm_enable_in),
		.period_in(pwm_period_in),
		.speed_in(spindle_speed_in),
		.speed_max_in(spindle_max_in),
		.pwm_out(spindle_pwm_out)
	);

	assign slow_out = slow_r;
	assign reverse_out = rev_r;
	assign stop_out = stop_r;
	assign pos_zero_out = zero_r;
	assign homing_out = homing_r;
	assign homed_out = homed_r;
	assign index_armed_out = arm_r;
	assign estop_out = estop_r;
	assign limit_src_out = src_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_zero_with_stop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pos_zero_out[0] |-> stop_out[0]) else $error("zero without stop"); // [R1]
	a_std_reverse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_r[0] == AHS_SEEK && home_s[0] && mode_r[1:0] == AHS_MODE_STD && !home_abort_in)
		|=> reverse_out[0] && slow_out[0]) else $error("std no reverse"); // [R1]
	a_alt_no_rev: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_r[1] == AHS_SEEK && home_s[1] && mode_r[3:2] == AHS_MODE_SLOW && !home_abort_in)
		|=> !reverse_out[1] && slow_out[1]) else $error("alt reversed"); // [R2]
	a_index_arm: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(st_r[2] == AHS_SEEK && home_s[2] && mode_r[5:4] == AHS_MODE_IDX && !home_abort_in)
		|=> index_armed_out[2] && slow_out[2]) else $error("index not armed"); // [R3]
	a_index_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(arm_r[2] && idx_edge[2] && !home_abort_in)
		|=> pos_zero_out[2] && !index_armed_out[2]) else $error("index no zero"); // [R4] [R15]
	a_abort_disarm: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		home_abort_in |=> index_armed_out == '0) else $error("armed after abort"); // [R15]
	a_limit_estop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(rise[0] && !mask[0]) |=> estop_out && limit_src_out[0]) else $error("no estop"); // [R8]
	a_masked_limit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(!estop_r && rise == (rise & mask)) |=> !estop_out) else $error("masked estop"); // [R9]
	a_high_ax_noarm: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!index_armed_out[N-1]) else $error("arm without channel"); // [R5]
endmodule

//--- ahs_motor_model.sv
// Purpose: far-side model of the axis motors, home cams and encoder index channels
// Assumes: one step every four clocks while an axis is being driven by the homing logic
// Notes: the home cam is a finite strip, so every homing mode eventually sees a release
`timescale 1ns/10ps
module ahs_motor_model import ahs_pkg::*; #(
	parameter int N = AHS_NUM_AXES,
	parameter int HIT = 12,
	parameter int WID = 8
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [N-1:0] homing_in,
	input wire logic [N-1:0] slow_in,
	input wire logic [N-1:0] reverse_in,
	input wire logic [N-1:0] homed_in,
	input wire logic [N-1:0] pos_zero_in,
	output logic [N-1:0] home_sw_out,
	output logic [N-1:0] step_pulse_out,
	output logic [AHS_NUM_IDX-1:0] index_out
);
	logic [1:0] div_r;
	logic signed [15:0] pos_r [N];

	////////////////////////////////////////////////////////////////////////////////
	// Step generator and position tracker; a zero request overrides any step
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_r <= 2'h0;
			step_pulse_out <= '0;
			index_out <= '0;
			for (int i = 0; i < N; i++) pos_r[i] <= 16'sh0000;
		end else begin
			div_r <= div_r + 2'h1;
			step_pulse_out <= '0;
			for (int i = 0; i < N; i++) begin
				if (pos_zero_in[i]) begin
					pos_r[i] <= 16'sh0000;
				end else if (div_r == 2'h0 && (homing_in[i] | slow_in[i] | reverse_in[i])
						&& !homed_in[i]) begin
					step_pulse_out[i] <= 1'b1;
					pos_r[i] <= reverse_in[i] ? pos_r[i] - 16'sh0001 : pos_r[i] + 16'sh0001;
					// Index line flips once per four steps, channel i+1 for motor i
					if (i < AHS_NUM_IDX && pos_r[i][1:0] == 2'h0) index_out[i] <= ~index_out[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Home cam active while the carriage sits on the strip
	always_comb begin
		for (int i = 0; i < N; i++) home_sw_out[i] = (pos_r[i] >= HIT) && (pos_r[i] < HIT + WID);
	end
endmodule

//--- axis_homing_and_spindle_output_test.sv
// Purpose: self-checking bench for the homing sequencer, limit supervision and spindle PWM
// Assumes: motor model supplies home cams, step pulses and index lines
// Notes: inputs change 1 ns after the rising edge; outputs are read at the same point
`timescale 1ns/10ps
module axis_homing_and_spindle_output_test;
	import ahs_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] home_start_in = '0, shared_limit_in = '0, limit_sw_in = '0;
	logic home_abort_in = 1'b0, mode_load_in = 1'b0, pwm_enable_in = 1'b0;
	logic [15:0] home_mode_in = '0, backoff_steps_in = '0;
	logic [15:0] pwm_period_in = 16'h0014, spindle_speed_in = '0, spindle_max_in = 16'h0014;
	logic [7:0] home_sw, step_pulse, slow_out, reverse_out, stop_out, pos_zero_out;
	logic [7:0] homing_out, homed_out, index_armed_out, limit_src_out;
	logic [2:0] index_w;
	logic estop_out, spindle_pwm_out;
	int error_cnt = 0, n_checks = 0, cyc = 0;

	ahs_top i_ahs_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .home_start_in(home_start_in),
		.home_abort_in(home_abort_in), .home_mode_in(home_mode_in), .mode_load_in(mode_load_in),
		.backoff_steps_in(backoff_steps_in), .shared_limit_in(shared_limit_in),
		.home_sw_in(home_sw), .limit_sw_in(limit_sw_in), .index_in(index_w),
		.step_pulse_in(step_pulse), .pwm_enable_in(pwm_enable_in), .pwm_period_in(pwm_period_in),
		.spindle_speed_in(spindle_speed_in), .spindle_max_in(spindle_max_in),
		.slow_out(slow_out), .reverse_out(reverse_out), .stop_out(stop_out),
		.pos_zero_out(pos_zero_out), .homing_out(homing_out), .homed_out(homed_out),
		.index_armed_out(index_armed_out), .estop_out(estop_out), .limit_src_out(limit_src_out),
		.spindle_pwm_out(spindle_pwm_out));
	ahs_motor_model i_ahs_motor_model (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.homing_in(homing_out), .slow_in(slow_out), .reverse_in(reverse_out),
		.homed_in(homed_out), .pos_zero_in(pos_zero_out), .home_sw_out(home_sw),
		.step_pulse_out(step_pulse), .index_out(index_w));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, cycle count and hang cut-off
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// One homing run on one axis, recording what the sequencer showed
	task automatic run_home(input int ax, input logic rev, input logic arm, output int bsteps);
		logic s_slow = 0, s_rev = 0, s_arm = 0, s_zero = 0, s_stop = 0;
		bsteps = 0;
		home_start_in[ax] = 1'b1;
		tick(1);
		home_start_in[ax] = 1'b0;
		for (int k = 0; k < 800 && !homed_out[ax]; k++) begin
			tick(1);
			s_slow |= slow_out[ax];
			s_rev |= reverse_out[ax] & !s_zero;
			s_arm |= index_armed_out[ax];
			s_stop |= stop_out[ax];
			// Pulses seen from the zeroing cycle on are back-off steps
			s_zero |= pos_zero_out[ax];
			if (s_zero && step_pulse[ax]) bsteps++;
		end
		chk({s_slow, s_zero, s_stop, homed_out[ax]}, 4'hF);
		chk(s_rev, rev);
		chk(s_arm, arm);
		chk(index_armed_out[ax], 1'b0);
	endtask

	task automatic t_modes();
		int b;
		run_home(0, 1'b1, 1'b0, b);
		home_mode_in = 16'h0024;
		mode_load_in = 1'b1;
		tick(1);
		mode_load_in = 1'b0;
		run_home(1, 1'b0, 1'b0, b);
		run_home(2, 1'b0, 1'b1, b);
		$display("Test homing modes done");
	endtask

	task automatic t_backoff();
		int b;
		backoff_steps_in = 16'h0003;
		run_home(0, 1'b1, 1'b0, b);
		chk(b, 32'h3);
		backoff_steps_in = 16'h0000;
		$display("Test back-off done");
	endtask

	// Series switch wired to the first axis limit only, as the host is expected to do
	task automatic t_limits();
		int b;
		limit_sw_in[0] = 1'b1;
		tick(8);
		chk({estop_out, limit_src_out}, 9'h101);
		limit_sw_in[0] = 1'b0;
		home_abort_in = 1'b1;
		tick(1);
		home_abort_in = 1'b0;
		tick(2);
		chk(estop_out, 1'b0);
		// Abort dropped homed; axis 0 homes again so its shared limit is masked later
		run_home(0, 1'b1, 1'b0, b);
		shared_limit_in = 8'h03;
		home_start_in[1] = 1'b1;
		tick(1);
		home_start_in[1] = 1'b0;
		tick(4);
		limit_sw_in[0] = 1'b1;
		tick(10);
		chk({estop_out, homing_out[1]}, 2'h1);
		limit_sw_in[0] = 1'b0;
		home_abort_in = 1'b1;
		tick(1);
		home_abort_in = 1'b0;
		tick(6);
		chk({estop_out, homing_out[1], index_armed_out}, 10'h000);
		$display("Test limits done");
	endtask

	// Settles for one period plus margin, then counts high cycles over three periods
	task automatic pwm_duty(input logic [15:0] spd, input logic en, input int per, input int exp);
		int hi = 0;
		spindle_speed_in = spd;
		pwm_enable_in = en;
		pwm_period_in = per[15:0];
		tick(per + 40);
		for (int k = 0; k < 3 * per; k++) begin
			tick(1);
			hi += spindle_pwm_out;
		end
		chk(hi, exp);
	endtask

	task automatic t_pwm();
		pwm_duty(16'h0005, 1'b1, 20, 15);
		pwm_duty(16'h0014, 1'b1, 20, 60);
		pwm_duty(16'h0014, 1'b0, 20, 0);
		// Converter rate: 10000 clocks per period, quarter speed gives quarter duty
		pwm_duty(16'h0005, 1'b1, AHS_PWM_PERIOD_RST, 7500);
		$display("Test spindle output done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tick(5);
		rst_b_in = 1'b1;
		chk({slow_out, reverse_out, homing_out, homed_out, estop_out}, 33'h0);
		$display("Test reset done");
		t_modes();
		t_backoff();
		t_limits();
		t_pwm();
		give_verdict();
	end
endmodule
